// [hw/iopc_unit.sv]
`timescale 1ns/1ps
`include "iopc_defines.svh"

module iopc_unit #(
    parameter int NPORT       = 64,
    parameter int IW          = 6,
    parameter int TICK_CYCLES = `IOPC_TICK_NS / `IOPC_CLK_NS
) (
    input  wire logic             clock,           // 40 MHz system clock
    input  wire logic             rstn,            // async reset, active low
    input  wire logic             clk_en,          // freezes all state when low
    input  wire logic             cmd_valid,       // command present, hold until cmd_done
    input  wire logic [2:0]       cmd_op,          // iopc_op_t code
    input  wire logic [IW-1:0]    cmd_start,       // first item index
    input  wire logic [IW-1:0]    cmd_end,         // last item index
    input  wire logic [13:0]      cmd_arg,         // ticks, digit count or format
    input  wire logic             cmd_has_time,    // wait timeout operand given
    input  wire logic [IW-1:0]    cmd_tout_idx,    // item set on wait timeout
    input  wire logic [31:0]      acc_in,          // accumulator value for writes
    input  wire logic             wait_cancel_cmd, // cancel from another program
    input  wire logic             prog_end,        // issuing program terminates
    input  wire logic [NPORT-1:0] io_in,           // observed level of every item
    output logic      [NPORT-1:0] io_out,          // driven outputs and flags
    output logic                  cmd_done,        // one-cycle completion pulse
    output logic      [31:0]      acc_out,         // accumulator result
    output logic                  acc_wr,          // accumulator write pulse
    output logic                  wait_timed_out   // last wait ended by timeout
);

    localparam int NT = `IOPC_TIMERS;
    localparam int EW = IW + 14;

    generate
        // the slot sweep takes two cycles per slot and must end before the next tick
        if (NPORT < 1 || NPORT > (1 << IW) || TICK_CYCLES < 2 * NT + 2) begin : g_bad
            $error("iopc_unit: unsupported parameter values");
        end
    endgenerate

    // ==========================================================
    // helpers
    function automatic logic [31:0] order_swap(input logic [31:0] v, input logic [1:0] f);
        logic [31:0] r;
        r = v;
        if (f[`IOPC_FMT_BYTE_BIT]) begin
            r = {r[23:16], r[31:24], r[7:0], r[15:8]};
        end
        if (f[`IOPC_FMT_HALF_BIT]) begin
            r = {r[15:0], r[31:16]};
        end
        return r;
    endfunction

    function automatic logic [31:0] gather(input logic [NPORT-1:0] src, input int s, input int len);
        logic [31:0] g;
        g = 32'h0;
        for (int k = 0; k < `IOPC_MAX_BITS; k++) begin
            if (k < len && s + k < NPORT) begin
                g[k] = src[s + k];
            end
        end
        return g;
    endfunction

    function automatic logic [31:0] bcd_to_bin(input logic [31:0] b, input int n);
        logic [31:0] d;
        d = 32'h0;
        for (int i = `IOPC_MAX_DIGITS - 1; i >= 0; i--) begin
            if (i < n) begin
                d = 32'(d * 32'd10) + {28'h0, b[i*4 +: 4]};
            end
        end
        return d;
    endfunction

    // ==========================================================
    // state
    iopc_pkg::iopc_cmd_state_t  cs;
    iopc_pkg::iopc_scan_state_t sc;
    iopc_pkg::iopc_op_t         op;
    logic [31:0]     tick_cnt;
    logic            tick;
    logic [1:0]      word_fmt;
    logic [NT-1:0]   active;
    logic [3:0]      ptr;
    logic [13:0]     wait_left;
    logic            wait_has_time;
    logic [IW-1:0]   wait_idx;
    logic            wait_high;
    logic [IW-1:0]   wait_tout_idx;
    logic [EW-1:0]   rdata;
    logic [3:0]      free_slot;
    logic            have_free;
    logic            accept;
    logic            level_met;
    logic            tmo_hit;
    logic            expire;
    logic            mem_we;
    logic [3:0]      mem_waddr;
    logic [EW-1:0]   mem_wdata;
    logic [13:0]     pulse_ticks;
    logic [31:0]     wr_word;
    int              rd_len;
    int              dig_n;

    assign op = iopc_pkg::iopc_op_t'(cmd_op);

    // lowest free timer slot
    always_comb begin
        free_slot = 4'h0;
        have_free = 1'b0;
        for (int i = NT - 1; i >= 0; i--) begin
            if (!active[i]) begin
                free_slot = 4'(i);
                have_free = 1'b1;
            end
        end
    end

    // a full timer table stalls the off pulse until a slot frees
    assign accept = (cs == iopc_pkg::IOPC_CS_IDLE) && cmd_valid && (sc == iopc_pkg::IOPC_SC_IDLE)
                    && !tick && !prog_end && (op != iopc_pkg::IOPC_OP_OFF_PULSE || have_free);

    // out-of-range durations are clamped into the supported window
    assign pulse_ticks = (cmd_arg < `IOPC_MIN_TICKS) ? `IOPC_MIN_TICKS :
                         (cmd_arg > `IOPC_MAX_TICKS) ? `IOPC_MAX_TICKS : cmd_arg;

    // range lengths capped at one word
    assign rd_len = (cmd_end < cmd_start) ? 0 :
                    ((int'(cmd_end) - int'(cmd_start) + 1 > 32) ? 32 : int'(cmd_end) - int'(cmd_start) + 1);
    assign dig_n  = (int'(cmd_arg) > `IOPC_MAX_DIGITS) ? `IOPC_MAX_DIGITS : int'(cmd_arg);

    // write word swapped once, ahead of the per-item loop
    assign wr_word = order_swap(acc_in, word_fmt);

    assign level_met = (io_in[wait_idx] == wait_high);
    assign tmo_hit   = tick && wait_has_time && (wait_left <= 14'd1);
    assign expire    = (sc == iopc_pkg::IOPC_SC_UPD) && active[ptr] && !prog_end
                       && (rdata[13:0] <= 14'd1);

    // ==========================================================
    // 10 ms tick
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_cnt <= 32'h0;
            tick     <= 1'b0;
        end else if (clk_en) begin
            tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    // ==========================================================
    // timer table
    assign mem_we    = (sc == iopc_pkg::IOPC_SC_UPD) ? active[ptr] :
                       (accept && op == iopc_pkg::IOPC_OP_OFF_PULSE);
    assign mem_waddr = (sc == iopc_pkg::IOPC_SC_UPD) ? ptr : free_slot;
    assign mem_wdata = (sc == iopc_pkg::IOPC_SC_UPD) ? {rdata[EW-1:14], rdata[13:0] - 14'd1}
                                                      : {cmd_start, pulse_ticks};

    iopc_pulse_mem #(
        .WIDTH (EW),
        .DEPTH (NT),
        .AW    (4)
    ) u_mem (
        .clock (clock),
        .en    (clk_en),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (ptr),
        .rdata (rdata)
    );

    // sweep every slot once per tick, two cycles per slot
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sc  <= iopc_pkg::IOPC_SC_IDLE;
            ptr <= 4'h0;
        end else if (clk_en) begin
            case (sc)
                iopc_pkg::IOPC_SC_IDLE: begin
                    ptr <= 4'h0;
                    if (tick) begin
                        sc <= iopc_pkg::IOPC_SC_READ;
                    end
                end
                iopc_pkg::IOPC_SC_READ: begin
                    sc <= iopc_pkg::IOPC_SC_UPD;
                end
                iopc_pkg::IOPC_SC_UPD: begin
                    ptr <= ptr + 4'h1;
                    sc  <= (ptr == 4'(NT - 1)) ? iopc_pkg::IOPC_SC_IDLE : iopc_pkg::IOPC_SC_READ;
                end
                default: begin
                    sc <= iopc_pkg::IOPC_SC_IDLE;
                end
            endcase
        end
    end

    // active slots; the wait cancel input is deliberately not looked at
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            active <= '0;
        end else if (clk_en) begin
            if (prog_end) begin
                active <= '0;
            end else if (expire) begin
                active[ptr] <= 1'b0;
            end else if (accept && op == iopc_pkg::IOPC_OP_OFF_PULSE) begin
                active[free_slot] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // word order setting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            word_fmt <= `IOPC_FMT_RESET;
        end else if (clk_en && accept && op == iopc_pkg::IOPC_OP_WORD_ORDER) begin
            word_fmt <= cmd_arg[1:0];
        end
    end

    // ==========================================================
    // command sequencing and wait
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cs             <= iopc_pkg::IOPC_CS_IDLE;
            cmd_done       <= 1'b0;
            wait_left      <= 14'h0;
            wait_has_time  <= 1'b0;
            wait_idx       <= '0;
            wait_high      <= 1'b0;
            wait_tout_idx  <= '0;
            wait_timed_out <= 1'b0;
        end else if (clk_en) begin
            cmd_done <= 1'b0;
            case (cs)
                iopc_pkg::IOPC_CS_IDLE: begin
                    if (accept && (op == iopc_pkg::IOPC_OP_WAIT_HIGH || op == iopc_pkg::IOPC_OP_WAIT_LOW)) begin
                        cs             <= iopc_pkg::IOPC_CS_WAIT;
                        wait_idx       <= cmd_start;
                        wait_high      <= (op == iopc_pkg::IOPC_OP_WAIT_HIGH);
                        wait_has_time  <= cmd_has_time;
                        wait_left      <= pulse_ticks;
                        wait_tout_idx  <= cmd_tout_idx;
                        wait_timed_out <= 1'b0;
                    end else if (accept) begin
                        cs       <= iopc_pkg::IOPC_CS_HOLD;
                        cmd_done <= 1'b1;
                    end
                end
                iopc_pkg::IOPC_CS_WAIT: begin
                    // level wins over a timeout landing in the same cycle
                    if (prog_end || wait_cancel_cmd || level_met) begin
                        cs       <= iopc_pkg::IOPC_CS_HOLD;
                        cmd_done <= 1'b1;
                    end else if (tmo_hit) begin
                        cs             <= iopc_pkg::IOPC_CS_HOLD;
                        cmd_done       <= 1'b1;
                        wait_timed_out <= 1'b1;
                    end else if (tick) begin
                        wait_left <= wait_left - 14'd1;
                    end
                end
                iopc_pkg::IOPC_CS_HOLD: begin
                    cs <= iopc_pkg::IOPC_CS_IDLE;
                end
                default: begin
                    cs <= iopc_pkg::IOPC_CS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // accumulator reads
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_out <= 32'h0;
            acc_wr  <= 1'b0;
        end else if (clk_en) begin
            acc_wr <= 1'b0;
            if (accept && op == iopc_pkg::IOPC_OP_BIN_READ) begin
                // a full 32-bit range lands with bit 31 as the sign
                acc_out <= order_swap(gather(io_in, int'(cmd_start), rd_len), word_fmt);
                acc_wr  <= 1'b1;
            end else if (accept && op == iopc_pkg::IOPC_OP_DEC_READ) begin
                acc_out <= bcd_to_bin(order_swap(gather(io_in, int'(cmd_start), dig_n * `IOPC_BCD_WIDTH),
                                                 word_fmt), dig_n);
                acc_wr  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // item outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            io_out <= '0;
        end else if (clk_en) begin
            if (expire) begin
                io_out[rdata[EW-1:14]] <= 1'b1;
            end
            if (accept && op == iopc_pkg::IOPC_OP_OFF_PULSE) begin
                io_out[cmd_start] <= 1'b0;
            end
            if (accept && op == iopc_pkg::IOPC_OP_BIN_WRITE) begin
                for (int j = 0; j < NPORT; j++) begin
                    if (j >= int'(cmd_start) && j - int'(cmd_start) < rd_len) begin
                        io_out[j] <= wr_word[j - int'(cmd_start)];
                    end
                end
            end
            if (cs == iopc_pkg::IOPC_CS_WAIT && !prog_end && !wait_cancel_cmd && !level_met && tmo_hit) begin
                io_out[wait_tout_idx] <= 1'b1;
            end
        end
    end

    // ==========================================================
    // checks
    sequence s_off_taken;
        clk_en && accept && op == iopc_pkg::IOPC_OP_OFF_PULSE;
    endsequence

    sequence s_off_result;
        cmd_done && !io_out[$past(cmd_start)];
    endsequence

    property p_off_clear;
        @(posedge clock) disable iff (!rstn) s_off_taken |=> s_off_result;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("off pulse did not clear item");

    property p_expire_on;
        @(posedge clock) disable iff (!rstn) (clk_en && expire) |=> io_out[$past(rdata[EW-1:14])];
    endproperty
    a_expire_on: assert property (p_expire_on) else $error("expired pulse not restored");

    property p_tick_range;
        @(posedge clock) disable iff (!rstn)
            s_off_taken |-> (mem_wdata[13:0] >= `IOPC_MIN_TICKS && mem_wdata[13:0] <= `IOPC_MAX_TICKS);
    endproperty
    a_tick_range: assert property (p_tick_range) else $error("pulse duration out of range");

    property p_end_abandon;
        @(posedge clock) disable iff (!rstn) (clk_en && prog_end) |=> (active == '0);
    endproperty
    a_end_abandon: assert property (p_end_abandon) else $error("timers survive program end");

    property p_cancel_immune;
        @(posedge clock) disable iff (!rstn)
            (clk_en && wait_cancel_cmd && cs == iopc_pkg::IOPC_CS_WAIT && !prog_end && !expire)
            |=> (active == $past(active));
    endproperty
    a_cancel_immune: assert property (p_cancel_immune) else $error("wait cancel disturbed timers");

    property p_wait_met;
        @(posedge clock) disable iff (!rstn)
            (clk_en && cs == iopc_pkg::IOPC_CS_WAIT && level_met) |=> (cmd_done && !wait_timed_out);
    endproperty
    a_wait_met: assert property (p_wait_met) else $error("wait did not end on level");

    property p_timeout_out;
        @(posedge clock) disable iff (!rstn)
            (clk_en && cs == iopc_pkg::IOPC_CS_WAIT && !prog_end && !wait_cancel_cmd && !level_met && tmo_hit)
            |=> (wait_timed_out && cmd_done && io_out[$past(wait_tout_idx)]);
    endproperty
    a_timeout_out: assert property (p_timeout_out) else $error("timeout output not set");

    property p_no_time_no_tmo;
        @(posedge clock) disable iff (!rstn)
            (clk_en && cs == iopc_pkg::IOPC_CS_WAIT && !wait_has_time) |=> !wait_timed_out;
    endproperty
    a_no_time_no_tmo: assert property (p_no_time_no_tmo) else $error("timeout without operand");

    property p_bin_plain;
        @(posedge clock) disable iff (!rstn)
            (clk_en && accept && op == iopc_pkg::IOPC_OP_BIN_READ && cmd_start == '0 && cmd_end == IW'(31)
             && word_fmt == 2'h0 && NPORT >= 32) |=> (acc_wr && acc_out == $past(io_in[31:0]));
    endproperty
    a_bin_plain: assert property (p_bin_plain) else $error("plain 32-bit read wrong");

    property p_fmt_hold;
        @(posedge clock) disable iff (!rstn)
            !(accept && op == iopc_pkg::IOPC_OP_WORD_ORDER) |=> (word_fmt == $past(word_fmt));
    endproperty
    a_fmt_hold: assert property (p_fmt_hold) else $error("word order changed by itself");

    property p_tick_single;
        @(posedge clock) disable iff (!rstn) (clk_en && tick) |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");

endmodule

// [pkg/iopc_defines.svh]
`ifndef IOPC_DEFINES_SVH
`define IOPC_DEFINES_SVH

// ==========================================================
// timing
`define IOPC_CLK_NS          25
`define IOPC_TICK_NS         10000000
// pulse and wait durations in 10 ms ticks (0.01 s .. 99.00 s)
`define IOPC_MIN_TICKS       14'd1
`define IOPC_MAX_TICKS       14'd9900

// ==========================================================
// data path limits and reset values
`define IOPC_MAX_BITS        32
`define IOPC_MAX_DIGITS      8
`define IOPC_BCD_WIDTH       4
`define IOPC_TIMERS          16
`define IOPC_FMT_RESET       2'h0
`define IOPC_FMT_BYTE_BIT    0
`define IOPC_FMT_HALF_BIT    1

`endif

// [pkg/iopc_pkg.sv]
package iopc_pkg;

    // commands from the step sequencer
    typedef enum logic [2:0] {
        IOPC_OP_OFF_PULSE  = 3'h0,
        IOPC_OP_WAIT_HIGH  = 3'h1,
        IOPC_OP_WAIT_LOW   = 3'h2,
        IOPC_OP_BIN_READ   = 3'h3,
        IOPC_OP_DEC_READ   = 3'h4,
        IOPC_OP_BIN_WRITE  = 3'h5,
        IOPC_OP_WORD_ORDER = 3'h6
    } iopc_op_t;

    typedef enum logic [1:0] {
        IOPC_CS_IDLE = 2'h0,
        IOPC_CS_WAIT = 2'h1,
        IOPC_CS_HOLD = 2'h2
    } iopc_cmd_state_t;

    typedef enum logic [1:0] {
        IOPC_SC_IDLE = 2'h0,
        IOPC_SC_READ = 2'h1,
        IOPC_SC_UPD  = 2'h2
    } iopc_scan_state_t;

endpackage

// [hw/iopc_pulse_mem.sv]
`timescale 1ns/1ps

// small timer store: one write port, registered read data
module iopc_pulse_mem #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic             clock,  // system clock
    input  wire logic             en,     // clock enable
    input  wire logic             we,     // write strobe
    input  wire logic [AW-1:0]    waddr,  // write address
    input  wire logic [WIDTH-1:0] wdata,  // write data
    input  wire logic [AW-1:0]    raddr,  // read address
    output logic      [WIDTH-1:0] rdata   // read data, one cycle late
);

    logic [WIDTH-1:0] mem [DEPTH];

    generate
        if (DEPTH > (1 << AW)) begin : g_bad
            $error("iopc_pulse_mem: depth exceeds address range");
        end
    endgenerate

    // no reset on the array: entries are only trusted when marked active
    always_ff @(posedge clock) begin
        if (en) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule

// [bench/iopc_seq_model.sv]
`timescale 1ns/1ps

// ==========================================
// step sequencer model, one command at a time
module iopc_seq_model (
    input  wire logic        clock,        // system clock
    input  wire logic        cmd_done,     // completion pulse
    output logic             cmd_valid,    // request
    output logic [2:0]       cmd_op,       // opcode
    output logic [5:0]       cmd_start,    // first item
    output logic [5:0]       cmd_end,      // last item
    output logic [13:0]      cmd_arg,      // ticks, digits, order
    output logic             cmd_has_time, // timeout given
    output logic [5:0]       cmd_tout_idx  // timeout item
);
    initial begin
        {cmd_valid, cmd_op, cmd_start, cmd_end, cmd_arg, cmd_has_time, cmd_tout_idx} = '0;
    end

    // caller keeps times, ranges and targets legal; ok low if no answer
    task automatic issue(input iopc_pkg::iopc_op_t op, input logic [5:0] s, e, input logic [13:0] a,
                         input logic h, input logic [5:0] t, input int bound, output bit ok);
        int n;
        ok = 1'b0;
        @(posedge clock);
        cmd_valid <= 1'b1;
        {cmd_op, cmd_start, cmd_end, cmd_arg, cmd_has_time, cmd_tout_idx} <= {op, s, e, a, h, t};
        for (n = 0; n < bound && !ok; n++) begin
            @(posedge clock);
            ok = (cmd_done === 1'b1);
        end
        // released start, end and arg operands garbled so nothing relies on their stale values
        cmd_valid <= 1'b0;
        {cmd_start, cmd_end, cmd_arg} <= ~{cmd_start, cmd_end, cmd_arg};
    endtask
endmodule

// [bench/tb_iopc_unit.sv]
`timescale 1ns/1ps

// ==========================================
// testbench
module tb_iopc_unit;
    logic        clock = 0;
    logic        rstn = 0;
    logic        ce = 1;
    logic        wcan, pend, done, accw, tmo, cv, ht;
    logic [2:0]  op;
    logic [5:0]  st, en, ti;
    logic [13:0] arg;
    logic [63:0] io_in, io_out;
    logic [31:0] acc_in, acc_out, v;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          checked = 0;
    int          seed = 82;
    int          k;
    bit          ok;

    always #12.5 clock = ~clock;

    iopc_seq_model SEQ (.clock(clock), .cmd_done(done), .cmd_valid(cv), .cmd_op(op), .cmd_start(st),
        .cmd_end(en), .cmd_arg(arg), .cmd_has_time(ht), .cmd_tout_idx(ti));
    iopc_unit #(.TICK_CYCLES(40)) DUT (.clock(clock), .rstn(rstn), .clk_en(ce), .cmd_valid(cv),
        .cmd_op(op), .cmd_start(st), .cmd_end(en), .cmd_arg(arg), .cmd_has_time(ht),
        .cmd_tout_idx(ti), .acc_in(acc_in), .wait_cancel_cmd(wcan), .prog_end(pend), .io_in(io_in),
        .io_out(io_out), .cmd_done(done), .acc_out(acc_out), .acc_wr(accw), .wait_timed_out(tmo));

    task automatic check(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one command; a missing answer ends the run
    task automatic cmd(input iopc_pkg::iopc_op_t o, input logic [5:0] s, e, input logic [13:0] a,
                       input logic h, input logic [5:0] t);
        SEQ.issue(o, s, e, a, h, t, 300, ok);
        if (!ok) begin
            check(32'h0, 32'h1);
            end_of_test();
        end
    endtask

    // own model of the word order swaps
    function automatic logic [31:0] swp(input logic [31:0] x, input int m);
        swp = x;
        if (m[0]) swp = {swp[23:16], swp[31:24], swp[7:0], swp[15:8]};
        if (m[1]) swp = {swp[15:0], swp[31:16]};
    endfunction

    // scoreboard: oldest expected value per accumulator write
    always @(posedge clock) begin
        if (accw === 1'b1) begin
            if (exp_q.size() == 0) check(acc_out, 32'hffffffff);
            else check(acc_out, exp_q.pop_front());
        end
    end

    initial begin
        io_in = {$random(seed), $random(seed)} | 64'h80000000;
        acc_in = $random(seed);
        {wcan, pend} = 2'h0;
        repeat (4) @(posedge clock);
        check(acc_out | io_out[31:0], 32'h0);
        rstn <= 1'b1;
        // reads under every order, first one on the default
        for (k = 0; k < 4; k++) begin
            exp_q.push_back(swp(io_in[31:0], k));
            cmd(iopc_pkg::IOPC_OP_BIN_READ, 0, 31, 0, 0, 0);
            cmd(iopc_pkg::IOPC_OP_WORD_ORDER, 0, 0, 14'((k + 1) % 4), 0, 0);
        end
        exp_q.push_back({24'h0, io_in[12:5]});
        cmd(iopc_pkg::IOPC_OP_BIN_READ, 5, 12, 0, 0, 0);
        io_in[39:8] <= 32'h12345678;
        exp_q.push_back(32'h4e);
        cmd(iopc_pkg::IOPC_OP_DEC_READ, 8, 0, 2, 0, 0);
        exp_q.push_back(32'h00bc614e);
        cmd(iopc_pkg::IOPC_OP_DEC_READ, 8, 0, 8, 0, 0);
        $display("read tests done");
        // writes: order 3 with random data, then order 0
        cmd(iopc_pkg::IOPC_OP_WORD_ORDER, 0, 0, 3, 0, 0);
        cmd(iopc_pkg::IOPC_OP_BIN_WRITE, 32, 63, 0, 0, 0);
        check(io_out[63:32], swp(acc_in, 3));
        cmd(iopc_pkg::IOPC_OP_WORD_ORDER, 0, 0, 0, 0, 0);
        acc_in <= $random(seed);
        cmd(iopc_pkg::IOPC_OP_BIN_WRITE, 0, 31, 0, 0, 0);
        check(io_out[31:0], acc_in);
        $display("write tests done");
        // fill all sixteen timers, the next one must stall
        for (k = 0; k < 16; k++) begin
            cmd(iopc_pkg::IOPC_OP_OFF_PULSE, 6'(k), 0, 9900, 0, 0);
            check(32'(io_out[k]), 32'h0);
        end
        SEQ.issue(iopc_pkg::IOPC_OP_OFF_PULSE, 16, 0, 3, 0, 0, 30, ok);
        check(32'(ok), 32'h0);
        pend <= 1'b1;
        @(posedge clock);
        pend <= 1'b0;
        cmd(iopc_pkg::IOPC_OP_OFF_PULSE, 16, 0, 3, 0, 0);
        cmd(iopc_pkg::IOPC_OP_OFF_PULSE, 0, 0, 2, 0, 0);
        wcan <= 1'b1;
        @(posedge clock);
        wcan <= 1'b0;
        repeat (25) @(posedge clock);
        check(32'(io_out[16]), 32'h0);
        repeat (100) @(posedge clock);
        check(io_out[16:0], 17'h10001);
        $display("pulse tests done");
        // waits: level match, timeout with output, cancel without time
        io_in[51:50] <= 2'h2;
        fork
            begin
                repeat (10) @(posedge clock);
                io_in[50] <= 1'b1;
            end
            cmd(iopc_pkg::IOPC_OP_WAIT_HIGH, 50, 0, 0, 0, 0);
        join
        check(32'(tmo), 32'h0);
        cmd(iopc_pkg::IOPC_OP_WAIT_LOW, 51, 0, 2, 1, 5);
        check({tmo, io_out[5]}, 32'h3);
        fork
            begin
                repeat (150) @(posedge clock);
                wcan <= 1'b1;
                @(posedge clock);
                wcan <= 1'b0;
            end
            cmd(iopc_pkg::IOPC_OP_WAIT_LOW, 51, 0, 2, 0, 6);
        join
        check({tmo, io_out[6]}, 32'h0);
        // frozen block must ignore a satisfied wait, then serve it
        io_in[50] <= 1'b0;
        ce <= 1'b0;
        SEQ.issue(iopc_pkg::IOPC_OP_WAIT_LOW, 50, 0, 0, 0, 0, 20, ok);
        check(32'(ok), 32'h0);
        ce <= 1'b1;
        cmd(iopc_pkg::IOPC_OP_WAIT_LOW, 50, 0, 0, 0, 0);
        $display("wait tests done");
        end_of_test();
    end
endmodule
